// File: design/sqt_pkg.sv
package sqt_pkg;
  // ********************************************
  // register offsets
  // ********************************************
  localparam logic [7:0] OFS_GLOBAL_QUEUE_SERVICE = 8'h05;
  localparam logic [7:0] OFS_TAG_PRI_MAP_LOW = 8'h0c;
  localparam logic [7:0] OFS_TAG_PRI_MAP_HIGH = 8'h0d;
  localparam logic [7:0] OFS_PORT1_QUEUE_TAG_CTL = 8'h10;
  localparam logic [7:0] OFS_PORT2_QUEUE_TAG_CTL = 8'h20;
  localparam logic [7:0] OFS_PORT3_QUEUE_TAG_CTL = 8'h30;
  localparam logic [7:0] OFS_PORT1_STATE_CTL = 8'h12;
  localparam logic [7:0] OFS_PORT2_STATE_CTL = 8'h22;
  localparam logic [7:0] OFS_PORT1_DEF_TAG_HI = 8'h13;
  localparam logic [7:0] OFS_PORT1_DEF_TAG_LO = 8'h14;
  localparam logic [7:0] OFS_PORT2_DEF_TAG_HI = 8'h23;
  localparam logic [7:0] OFS_PORT2_DEF_TAG_LO = 8'h24;
  localparam logic [7:0] OFS_PORT3_DEF_TAG_HI = 8'h33;
  localparam logic [7:0] OFS_PORT3_DEF_TAG_LO = 8'h34;
  localparam logic [7:0] OFS_CODEPOINT_FIRST = 8'h60;
  localparam logic [7:0] OFS_CODEPOINT_LAST = 8'h6f;
  localparam logic [7:0] OFS_EGRESS_DEF_TAG_SEL = 8'hc2;
  // ********************************************
  // field positions and values
  // ********************************************
  localparam int BIT_SPLIT_QUEUE = 0;
  localparam int BIT_TAG_REMOVE = 1;
  localparam int BIT_TAG_INSERT = 2;
  localparam int BIT_PORT_PRI_LO = 3;
  localparam int BIT_PORT_PRI_HI = 4;
  localparam int BIT_TAG_PRI_EN = 5;
  localparam int BIT_DSCP_PRI_EN = 6;
  localparam int BIT_PRI_CEILING = 7;
  localparam int BIT_WFQ_MODE = 3;
  localparam int BIT_STP_TX_EN = 2;
  localparam int BIT_STP_RX_EN = 1;
  localparam int BIT_STP_LEARN_DIS = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] TAG_PROTOCOL_IDENTIFIER = 16'h8100;
  localparam int TAG_BYTES = 4;
  localparam logic [1:0] PORT_CPU = 2'h3;
  localparam logic [1:0] QUEUE_TOP = 2'h3;
  localparam logic [1:0] QUEUE_LOW = 2'h0;
  // weighted service slots: queue 3 gets 8, 2 gets 4, 1 gets 2, 0 gets 1
  localparam logic [3:0] WFQ_SLOTS = 4'hf;
  typedef enum logic [1:0] {
    TAG_KEEP = 2'h0,
    TAG_INSERT = 2'h1,
    TAG_REMOVE = 2'h2,
    TAG_REPRI = 2'h3
  } sqt_tagop_t;
endpackage

// File: design/sqt_qos_port.sv
// Contract
// - four transmit queues per egress port; queue 3 highest, queue 0 lowest
// - queues split only when control bit 0 of that port is set
// - unsplit port sends every frame through one common queue
// - global bit 3 chooses strict priority or weighted fair service
// - port-based priority marks all port frames high, top queue when split
// - tagged frame's 3-bit priority mapped to queue via map registers
// - tag-priority classification only when port control bit 5 set
// - insertion bit 2 tags untagged frames with ingress default tag
// - never add a second tag to an already tagged frame
// - removal bit 1 strips tags; untagged frames pass unmodified
// - tag is four bytes: protocol identifier then control information
// - frame check sequence recomputed whenever tag inserted or removed
// - ceiling caps tag priority at ingress default tag priority
// - upper six type-of-service bits index the codepoint priority table
// - port 3 is the processor port and carries no tree state
// - ports 1 and 2 tree state from tx, rx, learn-disable bits
// - disabled and not learning: no user traffic, no learning
// - disabled but learning: learn, forward only to/from processor
// - all enabled: forward normally and learn
// - override static match still delivered to processor in any state
module sqt_qos_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic inValid,
  output logic inReady,
  input wire logic [1:0] inPort,
  input wire logic [1:0] inDest,
  input wire logic inTagged,
  input wire logic [2:0] inTagPri,
  input wire logic inIsIp,
  input wire logic [7:0] inTos,
  input wire logic inOverride,
  output logic outValid,
  input wire logic outReady,
  output logic outForward,
  output logic outLearn,
  output logic [1:0] outQueue,
  output logic [1:0] outTagOp,
  output logic [15:0] outTci,
  output logic outRecalcCrc,
  input wire logic schedReq,
  input wire logic [1:0] schedPort,
  input wire logic [3:0] schedPending,
  output logic schedValid,
  output logic [1:0] schedQueue
);
  typedef struct packed {
    logic forward;
    logic learn;
    logic [1:0] queue;
    logic [1:0] tagOp;
    logic [15:0] tag_control_information;
    logic recalc;
  } sqt_res_t;

  typedef struct packed {
    logic [7:0] svc;
    logic [15:0] priMap;
    logic [2:0][7:0] ctl;
    logic [1:0][7:0] stp;
    logic [2:0][15:0] defTag;
    logic [15:0][7:0] dscp;
    logic [7:0] egrSel;
    logic [7:0] rdData;
    logic [1:0] count;
    sqt_res_t e0;
    sqt_res_t e1;
    logic inReady;
    logic outValid;
    logic [3:0] slot;
    logic schedValid;
    logic [1:0] schedQueue;
  } sqt_state_t;

  sqt_state_t st_reg;
  sqt_state_t st_next;

  // ********************************************
  // helpers
  // ********************************************
  // highest queue first
  function automatic logic [1:0] top_pending(input logic [3:0] p);
    logic [1:0] q;
    q = sqt_pkg::QUEUE_LOW;
    for (int i = 0; i < 4; i++) begin
      if (p[i]) begin
        q = 2'(i);
      end
    end
    return q;
  endfunction

  // slot to favoured queue: 8 of 15 slots for queue 3, 4 for 2, 2 for 1
  function automatic logic [1:0] slot_queue(input logic [3:0] s);
    logic [1:0] q;
    q = 2'h0;
    if (!s[0]) begin
      q = 2'h3;
    end else if (!s[1]) begin
      q = 2'h2;
    end else if (!s[2]) begin
      q = 2'h1;
    end
    return q;
  endfunction

  // which bit of the egress select register pairs egress with ingress
  function automatic logic [2:0] sel_bit(input logic [1:0] eg,
                                         input logic [1:0] ig);
    logic [2:0] b;
    b = {eg - 2'h1, 1'b0};
    if (ig > eg) begin
      b = 3'(b + 3'h1);
    end
    return b;
  endfunction

  // ********************************************
  // classification
  // ********************************************
  sqt_res_t res;
  logic [7:0] inCtl;
  logic [7:0] egCtl;
  logic [15:0] inDef;
  logic [2:0] pri;
  logic [6:0] dscpIdx;
  logic inRx;
  logic inLearnOk;
  logic egTx;
  logic egLearnOk;
  logic toCpu;
  logic fromCpu;

  always_comb begin
    inCtl = st_reg.ctl[inPort - 2'h1];
    egCtl = st_reg.ctl[inDest - 2'h1];
    inDef = st_reg.defTag[inPort - 2'h1];
    toCpu = (inDest == sqt_pkg::PORT_CPU);
    fromCpu = (inPort == sqt_pkg::PORT_CPU);
    inRx = 1'b1;
    inLearnOk = 1'b1;
    egTx = 1'b1;
    egLearnOk = 1'b1;
    if (!fromCpu) begin
      inRx = st_reg.stp[inPort[1]][sqt_pkg::BIT_STP_RX_EN];
      inLearnOk = !st_reg.stp[inPort[1]][sqt_pkg::BIT_STP_LEARN_DIS];
    end
    if (!toCpu) begin
      egTx = st_reg.stp[inDest[1]][sqt_pkg::BIT_STP_TX_EN];
      egLearnOk = !st_reg.stp[inDest[1]][sqt_pkg::BIT_STP_LEARN_DIS];
    end
    res = '0;
    // normal forwarding needs rx on ingress and tx on egress
    res.forward = inRx && egTx;
    // learning state still passes processor traffic
    if ((!inRx && inLearnOk && toCpu) || (!egTx && egLearnOk && fromCpu)) begin
      res.forward = 1'b1;
    end
    // override match reaches processor from any state
    if (toCpu && inOverride) begin
      res.forward = 1'b1;
    end
    res.learn = inLearnOk;
    pri = inTagPri;
    if (inCtl[sqt_pkg::BIT_PRI_CEILING] && inTagPri > inDef[15:13]) begin
      pri = inDef[15:13];
    end
    // six codepoint bits pick two table bits
    dscpIdx = {inTos[7:2], 1'b0};
    res.queue = sqt_pkg::QUEUE_LOW;
    if (inCtl[sqt_pkg::BIT_DSCP_PRI_EN] && inIsIp) begin
      res.queue = st_reg.dscp[dscpIdx[6:3]][dscpIdx[2:0] +: 2];
    end
    if (inCtl[sqt_pkg::BIT_TAG_PRI_EN] && inTagged) begin
      res.queue = st_reg.priMap[{pri, 1'b0} +: 2];
    end
    if (inCtl[sqt_pkg::BIT_PORT_PRI_HI:sqt_pkg::BIT_PORT_PRI_LO] != 2'h0) begin
      res.queue = sqt_pkg::QUEUE_TOP;
    end
    if (!egCtl[sqt_pkg::BIT_SPLIT_QUEUE]) begin
      res.queue = sqt_pkg::QUEUE_LOW;
    end
    // four-byte tag, fixed protocol id added downstream
    res.tagOp = sqt_pkg::TAG_KEEP;
    if (inTagged && pri != inTagPri) begin
      res.tagOp = sqt_pkg::TAG_REPRI;
      res.tag_control_information = {pri, 13'h0000};
    end
    if (egCtl[sqt_pkg::BIT_TAG_REMOVE] && inTagged) begin
      res.tagOp = sqt_pkg::TAG_REMOVE;
      res.tag_control_information = '0;
    end
    // insert default tag; never on tagged frames
    if (egCtl[sqt_pkg::BIT_TAG_INSERT] && !inTagged && inPort != inDest
        && st_reg.egrSel[sel_bit(inDest, inPort)]) begin
      res.tagOp = sqt_pkg::TAG_INSERT;
      res.tag_control_information = inDef;
    end
    // any tag change recomputes the checksum
    res.recalc = (res.tagOp != sqt_pkg::TAG_KEEP);
  end

  // ********************************************
  // registers, buffer, scheduler
  // ********************************************
  logic push;
  logic pop;
  logic [1:0] pick;

  always_comb begin
    st_next = st_reg;
    push = inValid && st_reg.inReady;
    pop = (st_reg.count != 2'h0) && outReady;
    if (regWrEn) begin
      case (regAddr)
        sqt_pkg::OFS_GLOBAL_QUEUE_SERVICE: st_next.svc = regWrData;
        sqt_pkg::OFS_TAG_PRI_MAP_LOW: st_next.priMap[7:0] = regWrData;
        sqt_pkg::OFS_TAG_PRI_MAP_HIGH: st_next.priMap[15:8] = regWrData;
        sqt_pkg::OFS_PORT1_QUEUE_TAG_CTL: st_next.ctl[0] = regWrData;
        sqt_pkg::OFS_PORT2_QUEUE_TAG_CTL: st_next.ctl[1] = regWrData;
        sqt_pkg::OFS_PORT3_QUEUE_TAG_CTL: st_next.ctl[2] = regWrData;
        sqt_pkg::OFS_PORT1_STATE_CTL: st_next.stp[0] = regWrData;
        sqt_pkg::OFS_PORT2_STATE_CTL: st_next.stp[1] = regWrData;
        sqt_pkg::OFS_PORT1_DEF_TAG_HI: st_next.defTag[0][15:8] = regWrData;
        sqt_pkg::OFS_PORT1_DEF_TAG_LO: st_next.defTag[0][7:0] = regWrData;
        sqt_pkg::OFS_PORT2_DEF_TAG_HI: st_next.defTag[1][15:8] = regWrData;
        sqt_pkg::OFS_PORT2_DEF_TAG_LO: st_next.defTag[1][7:0] = regWrData;
        sqt_pkg::OFS_PORT3_DEF_TAG_HI: st_next.defTag[2][15:8] = regWrData;
        sqt_pkg::OFS_PORT3_DEF_TAG_LO: st_next.defTag[2][7:0] = regWrData;
        sqt_pkg::OFS_EGRESS_DEF_TAG_SEL: st_next.egrSel = regWrData;
        default: begin
          if (regAddr[7:4] == sqt_pkg::OFS_CODEPOINT_FIRST[7:4]) begin
            st_next.dscp[regAddr[3:0]] = regWrData;
          end
        end
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        sqt_pkg::OFS_GLOBAL_QUEUE_SERVICE: st_next.rdData = st_reg.svc;
        sqt_pkg::OFS_TAG_PRI_MAP_LOW: st_next.rdData = st_reg.priMap[7:0];
        sqt_pkg::OFS_TAG_PRI_MAP_HIGH: st_next.rdData = st_reg.priMap[15:8];
        sqt_pkg::OFS_PORT1_QUEUE_TAG_CTL: st_next.rdData = st_reg.ctl[0];
        sqt_pkg::OFS_PORT2_QUEUE_TAG_CTL: st_next.rdData = st_reg.ctl[1];
        sqt_pkg::OFS_PORT3_QUEUE_TAG_CTL: st_next.rdData = st_reg.ctl[2];
        sqt_pkg::OFS_PORT1_STATE_CTL: st_next.rdData = st_reg.stp[0];
        sqt_pkg::OFS_PORT2_STATE_CTL: st_next.rdData = st_reg.stp[1];
        sqt_pkg::OFS_PORT1_DEF_TAG_HI: st_next.rdData = st_reg.defTag[0][15:8];
        sqt_pkg::OFS_PORT1_DEF_TAG_LO: st_next.rdData = st_reg.defTag[0][7:0];
        sqt_pkg::OFS_PORT2_DEF_TAG_HI: st_next.rdData = st_reg.defTag[1][15:8];
        sqt_pkg::OFS_PORT2_DEF_TAG_LO: st_next.rdData = st_reg.defTag[1][7:0];
        sqt_pkg::OFS_PORT3_DEF_TAG_HI: st_next.rdData = st_reg.defTag[2][15:8];
        sqt_pkg::OFS_PORT3_DEF_TAG_LO: st_next.rdData = st_reg.defTag[2][7:0];
        sqt_pkg::OFS_EGRESS_DEF_TAG_SEL: st_next.rdData = st_reg.egrSel;
        default: begin
          st_next.rdData = sqt_pkg::REG_RESET;
          if (regAddr[7:4] == sqt_pkg::OFS_CODEPOINT_FIRST[7:4]) begin
            st_next.rdData = st_reg.dscp[regAddr[3:0]];
          end
        end
      endcase
    end
    // two-entry buffer: e0 is the head shown on the outputs
    case ({push, pop})
      2'b10: begin
        if (st_reg.count == 2'h0) begin
          st_next.e0 = res;
        end else begin
          st_next.e1 = res;
        end
        st_next.count = 2'(st_reg.count + 2'h1);
      end
      2'b01: begin
        st_next.e0 = st_reg.e1;
        st_next.count = 2'(st_reg.count - 2'h1);
      end
      2'b11: begin
        if (st_reg.count == 2'h1) begin
          st_next.e0 = res;
        end else begin
          st_next.e0 = st_reg.e1;
          st_next.e1 = res;
        end
      end
      default: begin
      end
    endcase
    st_next.inReady = (st_next.count != 2'h2);
    st_next.outValid = (st_next.count != 2'h0);
    pick = top_pending(schedPending);
    if (st_reg.svc[sqt_pkg::BIT_WFQ_MODE]
        && schedPending[slot_queue(st_reg.slot)]) begin
      pick = slot_queue(st_reg.slot);
    end
    // unsplit port uses queue 0 only
    if (!st_reg.ctl[schedPort - 2'h1][sqt_pkg::BIT_SPLIT_QUEUE]) begin
      pick = sqt_pkg::QUEUE_LOW;
    end
    st_next.schedValid = 1'b0;
    if (schedReq) begin
      st_next.schedValid = schedPending[pick];
      st_next.schedQueue = pick;
      st_next.slot = (st_reg.slot == sqt_pkg::WFQ_SLOTS - 4'h1) ? 4'h0
                     : 4'(st_reg.slot + 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.inReady <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign inReady = st_reg.inReady;
  assign outValid = st_reg.outValid;
  assign outForward = st_reg.e0.forward;
  assign outLearn = st_reg.e0.learn;
  assign outQueue = st_reg.e0.queue;
  assign outTagOp = st_reg.e0.tagOp;
  assign outTci = st_reg.e0.tag_control_information;
  assign outRecalcCrc = st_reg.e0.recalc;
  assign schedValid = st_reg.schedValid;
  assign schedQueue = st_reg.schedQueue;

  // ********************************************
  // assertions
  // ********************************************
  property p_strictTop;
    @(posedge clk) disable iff (reset)
    schedReq && !st_reg.svc[sqt_pkg::BIT_WFQ_MODE] && schedPending[3]
    && st_reg.ctl[schedPort - 2'h1][0] |=> schedQueue == 2'h3;
  endproperty
  a_strictTop: assert property (p_strictTop) else $error("strict not top");
  property p_unsplit;
    @(posedge clk) disable iff (reset)
    push && !egCtl[0] ##1 (st_reg.count == 2'h1) |-> outQueue == 2'h0;
  endproperty
  a_unsplit: assert property (p_unsplit) else $error("unsplit queue");
  property p_schedSplit;
    @(posedge clk) disable iff (reset)
    schedReq && !st_reg.ctl[schedPort - 2'h1][0] |=> schedQueue == 2'h0;
  endproperty
  a_schedSplit: assert property (p_schedSplit) else $error("split gate");
  property p_noDoubleTag;
    @(posedge clk) disable iff (reset)
    push && inTagged |-> res.tagOp != sqt_pkg::TAG_INSERT;
  endproperty
  a_noDoubleTag: assert property (p_noDoubleTag) else $error("double tag");
  property p_crc;
    @(posedge clk) disable iff (reset)
    outValid |-> outRecalcCrc == (outTagOp != sqt_pkg::TAG_KEEP);
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag");
  property p_override;
    @(posedge clk) disable iff (reset)
    push && inOverride && inDest == 2'h3 && st_reg.count == 2'h0
    |=> outValid && outForward;
  endproperty
  a_override: assert property (p_override) else $error("override lost");
  property p_noLearn;
    @(posedge clk) disable iff (reset)
    push && inPort != 2'h3 && st_reg.stp[inPort[1]][0]
    |-> !res.learn && (res.forward -> inDest == 2'h3 || egTx && inRx);
  endproperty
  a_noLearn: assert property (p_noLearn) else $error("disabled learns");
  property p_ceiling;
    @(posedge clk) disable iff (reset)
    push && inTagged && inCtl[7] && inTagPri > inDef[15:13]
    && !egCtl[1] |-> res.tag_control_information[15:13] == inDef[15:13];
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("ceiling");
  property p_wfqNoStarve;
    @(posedge clk) disable iff (reset)
    schedReq && st_reg.svc[3] && st_reg.slot == 4'h7 && schedPending[0]
    && st_reg.ctl[schedPort - 2'h1][0] |=> schedQueue == 2'h0;
  endproperty
  a_wfqNoStarve: assert property (p_wfqNoStarve) else $error("starve");
  c_full: cover property (@(posedge clk) st_reg.count == 2'h2);
  c_insert: cover property (@(posedge clk) outValid && outTagOp == 2'h1);
  c_wfq: cover property (@(posedge clk) schedValid && st_reg.svc[3]);
endmodule

// File: sim/sqt_sink_model.sv
// ****
// egress consumer with random stalls
// ****
module sqt_sink_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 17221;
  initial outReady = 1'b0;
  // a real consumer is not always ready; hold stalls it fully
  always @(posedge clk) begin
    outReady <= !reset && !hold && ($random(seed) % 4 != 0);
  end
endmodule

// File: sim/test_sqt_qos_port.sv
module test_sqt_qos_port;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic inValid = 1'b0;
  logic inReady;
  logic [1:0] inPort = 2'h1;
  logic [1:0] inDest = 2'h2;
  logic inTagged = 1'b0;
  logic [2:0] inTagPri = 3'h0;
  logic inIsIp = 1'b0;
  logic [7:0] inTos = 8'h00;
  logic inOverride = 1'b0;
  logic outValid, outReady, outForward, outLearn, outRecalcCrc;
  logic [1:0] outQueue, outTagOp, schedQueue;
  logic [15:0] outTci;
  logic schedReq = 1'b0;
  logic [1:0] schedPort = 2'h1;
  logic [3:0] schedPending = 4'h0;
  logic schedValid;
  logic hold = 1'b0;
  logic rdPend = 1'b0;
  logic countOn = 1'b0;
  logic [7:0] rm [256] = '{default: 8'h00};
  logic [22:0] descQ [$];
  logic [7:0] regQ [$];
  logic [3:0] schedQ [$];
  int grants [4] = '{default: 0};
  int badCount = 0;
  int checkCount = 0;
  int seed = 17221;
  logic [31:0] r;
  logic [1:0] i, e;
  wire logic [22:0] outAll = {outForward, outLearn, outQueue, outTagOp,
    outTci, outRecalcCrc};

  always #10 clk = ~clk;

  sqt_qos_port u_dut (.clk, .reset, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .inValid, .inReady, .inPort, .inDest,
    .inTagged, .inTagPri, .inIsIp, .inTos, .inOverride, .outValid,
    .outReady, .outForward, .outLearn, .outQueue, .outTagOp, .outTci,
    .outRecalcCrc, .schedReq, .schedPort, .schedPending, .schedValid,
    .schedQueue);

  sqt_sink_model u_sink (.clk, .reset, .hold, .outReady);

  // ****
  // reference model
  // ****
  function automatic bit mapped(logic [7:0] a);
    return a inside {8'h05, 8'h0c, 8'h0d, 8'h10, 8'h12, 8'h13, 8'h14,
      8'h20, 8'h22, 8'h23, 8'h24, 8'h30, 8'h33, 8'h34, 8'hc2,
      [8'h60:8'h6f]};
  endfunction

  function automatic logic [22:0] model(logic [1:0] pi, pe, logic t,
    logic ip, logic ov, logic [2:0] p, logic [7:0] tos);
    logic [7:0] ci, ce, m;
    logic [2:0] si, se;
    logic [15:0] dt, mp, tag_control_information;
    logic [1:0] q, op;
    logic f;
    int c, k;
    ci = rm[{2'b00, pi, 4'h0}];
    ce = rm[{2'b00, pe, 4'h0}];
    si = (pi == 2'h3) ? 3'b110 : rm[{2'b00, pi, 4'h2}][2:0];
    se = (pe == 2'h3) ? 3'b110 : rm[{2'b00, pe, 4'h2}][2:0];
    dt = {rm[{2'b00, pi, 4'h3}], rm[{2'b00, pi, 4'h4}]};
    mp = {rm[8'h0d], rm[8'h0c]};
    c = int'(tos[7:2]);
    m = rm[8'h60 + c / 4];
    k = 2 * (int'(pe) - 1) + int'(pi > pe);
    // forwarding by state
    // learning state is receive off at ingress, transmit off at egress, with learning allowed
    f = (si[1] & se[2]) | (pi == 2'h3 & !se[2] & !se[0])
      | (pe == 2'h3 & ((!si[1] & !si[0]) | ov));
    q = !ce[0] ? 2'h0 : ci[4:3] != 2'h0 ? 2'h3 : (ci[5] & t) ? mp[2*p +: 2]
      : (ci[6] & ip) ? m[2*(c%4) +: 2] : 2'h0;
    op = (ce[1] & t) ? 2'h2 : (ce[2] & !t & rm[8'hc2][k]) ? 2'h1
      : (ci[7] & t & p > dt[15:13]) ? 2'h3 : 2'h0;
    tag_control_information = op == 2'h1 ? dt : op == 2'h3 ? {dt[15:13], 13'h0} : 16'h0000;
    return {f, !si[0], q, op, tag_control_information, op != 2'h0};
  endfunction

  // ****
  // compares
  // ****
  task automatic note(input logic ok, input logic [22:0] x, g);
    checkCount++;
    if (!ok) begin
      badCount++;
      $display("BAD t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic cmpDesc(input logic [22:0] x, g);
    note(g === x, x, g);
  endtask
  task automatic cmpReg(input logic [7:0] x, g);
    note(g === x, {15'h0, x}, {15'h0, g});
  endtask
  task automatic cmpSched(input logic [3:0] x, input logic [1:0] g);
    note(x[g] === 1'b1, {19'h0, x}, {21'h0, g});
  endtask

  always @(posedge clk) rdPend <= regRdEn & !reset;
  always @(negedge clk) begin
    if (rdPend) cmpReg(regQ.size() ? regQ.pop_front() : 'x, regRdData);
    if (outValid === 1'b1 && outReady === 1'b1)
      cmpDesc(descQ.size() ? descQ.pop_front() : 'x, outAll);
    if (schedValid === 1'b1) begin
      cmpSched(schedQ.size() ? schedQ.pop_front() : 4'h0, schedQueue);
      if (countOn) grants[schedQueue]++;
    end
  end

  // ****
  // drivers
  // ****
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    if (mapped(a)) rm[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    regQ.push_back(rm[a]);
  endtask
  // entered at a rising edge; leaves inValid up at the take edge
  task automatic send(input logic [1:0] pi, pe, input logic t, ip, ov,
    input logic [2:0] p, input logic [7:0] tos);
    int n = 0;
    inValid <= 1'b1;
    inPort <= pi;
    inDest <= pe;
    inTagged <= t;
    inIsIp <= ip;
    inOverride <= ov;
    inTagPri <= p;
    inTos <= tos;
    @(negedge clk);
    while (inReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) badCount++;
    @(posedge clk);
    descQ.push_back(model(pi, pe, t, ip, ov, p, tos));
  endtask
  task automatic sched(input logic [3:0] pend, input logic [1:0] port,
    input logic wfq);
    @(posedge clk);
    schedReq <= 1'b1;
    schedPending <= pend;
    schedPort <= port;
    @(posedge clk);
    schedReq <= 1'b0;
    if (pend != 4'h0)
      schedQ.push_back(wfq ? pend : pend[3] ? 4'h8 : pend[2] ? 4'h4
        : pend[1] ? 4'h2 : 4'h1);
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    stopTest();
  end

  // ****
  // main sequence
  // ****
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 256; a++) rd(a[7:0]);
    for (int a = 0; a < 256; a++) begin
      r = $random(seed);
      wr(a[7:0], r[7:0]);
    end
    for (int a = 0; a < 256; a++) rd(a[7:0]);
    repeat (40) begin
      for (int a = 0; a < 256; a++) begin
        r = $random(seed);
        // removal and insertion, ceiling and tag class kept apart
        if (a == 16 || a == 32 || a == 48) begin
          if (r[1]) r[2] = 1'b0;
          if (r[5]) r[7] = 1'b0;
        end
        if (mapped(a[7:0])) wr(a[7:0], r[7:0]);
      end
      repeat (20) begin
        r = $random(seed);
        i = (r[1:0] == 2'h0) ? 2'h1 : r[1:0];
        // destination is another of ports 1 to 3, never 0 and never the ingress port
        e = (r[3:2] == 2'h0 || r[3:2] == i) ? ((i == 2'h3) ? 2'h1 : 2'h3)
          : r[3:2];
        // processor sends nothing to a port that is disabled and not learning
        if (i == 2'h3 && rm[{2'b00, e, 4'h2}][2:0] == 3'b001) continue;
        send(i, e, r[4], r[5], r[6], r[9:7], r[17:10]);
      end
      inValid <= 1'b0;
    end
    repeat (40) @(posedge clk);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    send(2'h1, 2'h3, 1'b1, 1'b0, 1'b1, 3'h5, 8'h00);
    send(2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 3'h0, 8'hfc);
    inValid <= 1'b0;
    @(negedge clk);
    cmpReg(8'h00, {7'h0, inReady});
    @(posedge clk);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    wr(8'h05, 8'h00);
    for (int p = 1; p < 4; p++) wr(8'(p * 16), 8'h01);
    repeat (30) begin
      r = $random(seed);
      sched(r[3:0], r[5:4] == 2'h0 ? 2'h1 : r[5:4], 1'b0);
    end
    wr(8'h05, 8'h08);
    countOn <= 1'b1;
    repeat (15) sched(4'hf, 2'h1, 1'b1);
    // let the grant counter see the last grant before reading it
    @(negedge clk);
    @(posedge clk);
    for (int q = 0; q < 4; q++) cmpReg(8'(1 << q), 8'(grants[q]));
    repeat (20) begin
      r = $random(seed);
      sched(r[3:0], 2'h2, 1'b1);
    end
    repeat (40) @(posedge clk);
    cmpReg(8'h00, 8'(descQ.size() + regQ.size() + schedQ.size()));
    stopTest();
  end
endmodule
